// >>> parallel_result_upper_bus_pins_tb_top.sv
// testbench: two-pulse reads, serial reuse, reference and busy
`timescale 1ns/100ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module parallel_result_upper_bus_pins_tb_top;
    logic clk, rst_n, cnvStart, refSel, serMode, swMode, chOne, cnvDone, serC, serD, sdi, cs_n, rd_n;
    logic serIn, adv, busy, flag, refEn;
    prb_pkg::prb_lines_e lines;
    logic [17:0] result;
    logic [17:0] q[$]; // expected results, oldest first
    logic [15:0] busIn, busOut, busOe_n, v1, v2;
    int err_count = 0;
    int checked = 0;
    int advCount = 0; // completed result pairs seen
    // count end-of-pair pulses from the device
    always @(posedge clk) if (adv) advCount <= advCount + 1;
    prb_result_bus dut (.clk(clk), .rst_n(rst_n), .chipSelect_n(cs_n), .readStrobe_n(rd_n),
        .conversion_start(cnvStart), .refSelect(refSel), .serialMode(serMode), .softwareMode(swMode),
        .doutLines(lines), .resultData(result), .resultIsChannelOne(chOne), .conversionDone(cnvDone),
        .serialOutC(serC), .serialOutD(serD), .busIn(busIn), .busOut(busOut), .busOe_n(busOe_n),
        .serialIn(serIn), .resultAdvance(adv), .busy(busy), .first_channel_flag(flag), .intRefEnable(refEn));
    prb_host_model host (.clk(clk), .busOut(busOut), .busOe_n(busOe_n), .serialMode(serMode), .sdi(sdi),
        .chipSelect_n(cs_n), .readStrobe_n(rd_n), .busIn(busIn));
    task automatic stop_test;
        err_count += host.errs;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // watchdog: run needs about 320 cycles
    initial begin
        #20000;
        err_count++;
        stop_test();
    end
    initial begin
        {rst_n, cnvStart, refSel, serMode, swMode, chOne, cnvDone, serC, serD, sdi} = '0;
        lines = prb_pkg::PRB_DOUT_ONE;
        result = '0;
        void'($urandom(91));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        // pairs of reads; the third pair is abandoned after its first pulse
        for (int k = 0; k < 6; k++) begin
            result = (k == 0) ? 18'h3FFFF : 18'($urandom());
            q.push_back(result);
            chOne = 1'(k & 1);
            host.select(1'b0);
            host.pulse(v1);
            `CHK("flagPar", chOne, flag)
            if (k != 2) host.pulse(v2);
            host.select(1'b1);
            repeat (4) @(negedge clk);
            `CHK("first", q[0][17:2], v1)
            if (k != 2) `CHK("second", {q[0][1:0], 14'h0000}, v2)
            void'(q.pop_front());
        end
        `CHK("pairs", 5, advCount)
        $display("test parallel pairs done");
        serMode = 1'b1;
        swMode = 1'b1;
        for (int m = 0; m < 4; m++) begin
            lines = prb_pkg::prb_lines_e'(m);
            serC = 1'($urandom());
            serD = ~serC;
            sdi = 1'(m >> 1);
            repeat (10) @(negedge clk);
            `CHK("oeCD", {2{1'(m < 2)}}, busOe_n[10:9])
            if (m >= 2) `CHK("outCD", {serD, serC}, busOut[10:9])
            `CHK("sdi", sdi, serIn)
            `CHK("upperHiz", 4'hF, busOe_n[15:12])
        end
        chOne = 1'b1;
        host.select(1'b0);
        repeat (10) @(negedge clk);
        `CHK("flagOn", 1'b1, flag)
        host.select(1'b1);
        repeat (10) @(negedge clk);
        `CHK("flagOff", 1'b0, flag)
        $display("test serial reuse done");
        for (int b = 1; b >= 0; b--) begin
            refSel = 1'(b);
            repeat (10) @(negedge clk);
            `CHK("ref", 1'(b), refEn)
        end
        `CHK("busyIdle", 1'b0, busy)
        cnvStart = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("busyUp", 1'b1, busy)
        cnvStart = 1'b0;
        repeat (20) @(negedge clk);
        `CHK("busyHold", 1'b1, busy)
        cnvDone = 1'b1;
        @(negedge clk);
        cnvDone = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("busyDown", 1'b0, busy)
        $display("test reference and busy done");
        stop_test();
    end
endmodule : parallel_result_upper_bus_pins_tb_top
bind prb_result_bus prb_result_bus_assertions #(.RESULT_W(RESULT_W), .BUS_W(BUS_W)) chk (.clk(clk), .rst_n(rst_n),
    .chipSelect_n(chipSelect_n), .readStrobe_n(readStrobe_n), .conversion_start(conversion_start),
    .conversionDone(conversionDone), .refSelect(refSelect), .serialMode(serialMode), .softwareMode(softwareMode),
    .doutLines(doutLines), .resultData(resultData), .resultIsChannelOne(resultIsChannelOne), .busIn(busIn),
    .busOut(busOut), .busOe_n(busOe_n), .serialIn(serialIn), .resultAdvance(resultAdvance), .busy(busy),
    .first_channel_flag(first_channel_flag), .intRefEnable(intRefEnable));

// >>> prb_consts.svh
// constants for the parallel result bus upper-line block
`ifndef PRB_CONSTS_SVH
`define PRB_CONSTS_SVH
`define PRB_RESULT_W      18
`define PRB_BUS_W         16
`define PRB_UPPER_LO      2
`define PRB_SPLIT_LO      2
`define PRB_LINE_SER_C    9
`define PRB_LINE_SER_D    10
`define PRB_LINE_SER_IN   11
`endif

// >>> prb_host_model.sv
// host model: strobes reads and resolves the bus lines
`timescale 1ns/100ps
module prb_host_model (
    input  wire logic        clk,          // system clock
    input  wire logic [15:0] busOut,       // device drive values
    input  wire logic [15:0] busOe_n,      // device enables, low drives
    input  wire logic        serialMode,   // serial chosen
    input  wire logic        sdi,          // host serial data
    output logic             chipSelect_n, // select, active low
    output logic             readStrobe_n, // read, active low
    output logic      [15:0] busIn         // resolved levels
);
    logic [15:0] last = 16'h0000; // last levels, inverted when floating
    int          errs = 0;        // waits that ran out
    initial begin
        chipSelect_n = 1'b1;
        readStrobe_n = 1'b1;
    end
    always @(posedge clk) last <= busIn;
    // floating lines toggle; serial ties upper lines low and drives line 13
    always_comb begin
        for (int i = 0; i < 16; i++) busIn[i] = !busOe_n[i] ? busOut[i] : ~last[i];
        if (serialMode) begin
            busIn[15:12] = 4'h0;
            busIn[11] = sdi;
        end
    end
    task automatic select(input logic v);
        chipSelect_n = v;
    endtask : select
    // one read pulse, held until 2 cycles after drive seen, then gap of 8 cycles
    task automatic pulse(output logic [15:0] v);
        int n;
        n = 0;
        readStrobe_n = 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (busOe_n !== 16'h0000 && n < 20);
        repeat (2) @(negedge clk);
        v = busIn;
        readStrobe_n = 1'b1;
        repeat (8) @(negedge clk);
        if (n >= 20) errs++;
    endtask : pulse
endmodule : prb_host_model

// >>> prb_pin_sync.sv
// three-flop input synchroniser with agreement filter
`timescale 1ns/100ps
module prb_pin_sync #(
    parameter int W         = 1,
    parameter bit RESET_VAL = 1'b1
) (
    input  wire logic         clk,    // system clock
    input  wire logic         rst_n,  // async reset, active low
    input  wire logic [W-1:0] pinIn,  // raw pin levels
    output logic      [W-1:0] pinOut  // filtered levels
);
    logic [W-1:0] s1_r;  // first stage, read by second only
    logic [W-1:0] s2_r;  // second stage
    logic [W-1:0] s3_r;  // third stage

    // ---------------------------------------------------------------
    // sync chain and agreement filter
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r   <= {W{RESET_VAL}};
            s2_r   <= {W{RESET_VAL}};
            s3_r   <= {W{RESET_VAL}};
            pinOut <= {W{RESET_VAL}};
        end else begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin  // change counts once both agree
                    pinOut[i] <= s3_r[i];
                end
            end
        end
    end
endmodule : prb_pin_sync

// >>> prb_pkg.sv
// types for the parallel result bus upper-line block
package prb_pkg;
    typedef enum logic [1:0] {PRB_DOUT_ONE, PRB_DOUT_TWO, PRB_DOUT_FOUR, PRB_DOUT_EIGHT} prb_lines_e;
    typedef enum {PRB_IDLE, PRB_FIRST, PRB_GAP, PRB_SECOND} prb_phase_e;
endpackage : prb_pkg

// >>> prb_result_bus.sv
// parallel result bus: two-pulse 18-bit read-out, serial reuse, reference select
//
// Summary of operation
// - drive bus only while select and read low in parallel mode; serial software 4/8 lines also drive lines 11,12
// - line 11: bit 11, then zero
// - line 12: bit 12, then zero
// - line 13: bit 13, then zero
// - lines 14,15: bits, then zeros
// - line 16: bit 16, then bit 0
// - line 17: bit 17, then bit 1
// - serial software 4/8 lines: line 11 out C
// - serial software 4/8 lines: line 12 out D
// - serial software mode: line 13 data in
// - reference select high enables internal reference
// - lines 2-10: bits, then zeros
// - busy rises with start, holds until done
// - first-channel flag marks channel one read-back
`timescale 1ns/100ps
`include "prb_consts.svh"
module prb_result_bus #(
    parameter int RESULT_W = `PRB_RESULT_W,
    parameter int BUS_W    = `PRB_BUS_W
) (
    input  wire logic                clk,                 // 250 MHz system clock
    input  wire logic                rst_n,               // async reset, active low
    input  wire logic                chipSelect_n,        // chip select pin, active low
    input  wire logic                readStrobe_n,        // read strobe pin, active low
    input  wire logic                conversion_start,    // conversion start pin
    input  wire logic                refSelect,           // reference select pin
    input  wire logic                serialMode,          // serial interface chosen
    input  wire logic                softwareMode,        // software mode active
    input  wire prb_pkg::prb_lines_e doutLines,           // serial output line option
    input  wire logic [RESULT_W-1:0] resultData,          // result of current channel
    input  wire logic                resultIsChannelOne,  // current result is channel_one
    input  wire logic                conversionDone,      // all channels converted, pulse
    input  wire logic                serialOutC,          // serial out C data
    input  wire logic                serialOutD,          // serial out D data
    input  wire logic [BUS_W-1:0]    busIn,               // bus line levels seen at pins
    output logic      [BUS_W-1:0]    busOut,              // bus line drive values
    output logic      [BUS_W-1:0]    busOe_n,             // bus output enables, low drives
    output logic                     serialIn,            // sampled serial data input
    output logic                     resultAdvance,       // pulse: result pair fully read
    output logic                     busy,                // conversion in progress
    output logic                     first_channel_flag,  // channel_one being read back
    output logic                     intRefEnable         // internal reference enabled
);
    // refuse widths that the line mapping cannot serve
    if (RESULT_W != BUS_W + `PRB_SPLIT_LO || BUS_W < `PRB_LINE_SER_IN + 1) begin : gBadWidths
        $error("prb_result_bus: widths unsupported");
    end

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [4:0] pinSync;  // filtered cs, rd, start, ref, serial-in
    prb_pin_sync #(.W(5), .RESET_VAL(1'b1)) uSync (
        .clk    (clk),
        .rst_n  (rst_n),
        .pinIn  ({chipSelect_n, readStrobe_n, conversion_start, refSelect, busIn[`PRB_LINE_SER_IN]}),
        .pinOut (pinSync)
    );
    logic csLow;      // chip select asserted
    logic rdLow;      // read strobe asserted
    logic startSync;  // synchronised start
    logic refSync;    // synchronised reference select
    logic sdiSync;    // synchronised serial input
    assign csLow     = ~pinSync[4];
    assign rdLow     = ~pinSync[3];
    assign startSync = pinSync[2];
    assign refSync   = pinSync[1];
    assign sdiSync   = pinSync[0];

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    logic wideSerial;  // four or eight output lines in software mode
    assign wideSerial = serialMode && softwareMode &&
                        (doutLines == prb_pkg::PRB_DOUT_FOUR || doutLines == prb_pkg::PRB_DOUT_EIGHT);
    logic readActive;  // parallel read in progress
    assign readActive = !serialMode && csLow && rdLow;

    // ---------------------------------------------------------------
    // read pulse phase tracking
    // ---------------------------------------------------------------
    prb_pkg::prb_phase_e phase_r;  // which read pulse is active
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r  <= prb_pkg::PRB_IDLE;
        end else begin
            case (phase_r)
                prb_pkg::PRB_IDLE:   if (readActive) phase_r <= prb_pkg::PRB_FIRST;
                prb_pkg::PRB_FIRST:  if (!readActive) phase_r <= prb_pkg::PRB_GAP;
                prb_pkg::PRB_GAP: begin
                    if (readActive) phase_r <= prb_pkg::PRB_SECOND;
                    else if (!csLow || serialMode) phase_r <= prb_pkg::PRB_IDLE;  // abandoned pair
                end
                prb_pkg::PRB_SECOND: if (!readActive) phase_r <= prb_pkg::PRB_IDLE;
                default:             phase_r <= prb_pkg::PRB_IDLE;
            endcase
        end
    end

    // result pair completed on end of second pulse
    assign resultAdvance = (phase_r == prb_pkg::PRB_SECOND) && !readActive;

    // ---------------------------------------------------------------
    // result latch: held for both pulses of one result
    // ---------------------------------------------------------------
    logic [RESULT_W-1:0] held_r;  // result captured at first pulse
    logic                heldCh1_r;  // captured result is channel_one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_r    <= '0;
            heldCh1_r <= 1'b0;
        end else if (phase_r == prb_pkg::PRB_IDLE && readActive) begin
            held_r    <= resultData;
            heldCh1_r <= resultIsChannelOne;
        end
    end

    // ---------------------------------------------------------------
    // bus data and enables, registered
    // ---------------------------------------------------------------
    logic secondPulse;  // next drive is the second pulse
    assign secondPulse = (phase_r == prb_pkg::PRB_GAP) || (phase_r == prb_pkg::PRB_SECOND);
    logic [BUS_W-1:0] srcWord;  // value to drive this pulse
    always_comb begin
        srcWord = '0;
        if (phase_r == prb_pkg::PRB_IDLE) begin
            srcWord = resultData[RESULT_W-1:`PRB_UPPER_LO];
        end else if (!secondPulse) begin
            srcWord = held_r[RESULT_W-1:`PRB_UPPER_LO];
        end else begin
            srcWord[BUS_W-2] = held_r[0];
            srcWord[BUS_W-1] = held_r[1];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busOut  <= '0;
            busOe_n <= '1;
        end else begin
            busOut  <= '0;
            busOe_n <= '1;
            if (readActive) begin
                busOut  <= srcWord;
                busOe_n <= '0;
            end else if (wideSerial) begin
                busOut[`PRB_LINE_SER_C]  <= serialOutC;
                busOe_n[`PRB_LINE_SER_C] <= 1'b0;
                busOut[`PRB_LINE_SER_D]  <= serialOutD;
                busOe_n[`PRB_LINE_SER_D] <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // serial data input
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serialIn <= 1'b0;
        end else begin
            serialIn <= (serialMode && softwareMode) ? sdiSync : 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // busy flag
    // ---------------------------------------------------------------
    logic startD_r;  // previous start level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            startD_r <= 1'b1;  // matches sync reset level, no false edge
            busy     <= 1'b0;
        end else begin
            startD_r <= startSync;
            if (startSync && !startD_r) begin
                busy <= 1'b1;
            end else if (conversionDone) begin
                busy <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // first channel flag and reference
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_channel_flag <= 1'b0;
            intRefEnable       <= 1'b0;
        end else begin
            if (phase_r == prb_pkg::PRB_IDLE && readActive) begin
                first_channel_flag <= resultIsChannelOne;
            end else if (serialMode) begin
                first_channel_flag <= resultIsChannelOne && csLow;
            end else if (phase_r != prb_pkg::PRB_IDLE) begin
                first_channel_flag <= heldCh1_r;
            end else begin
                first_channel_flag <= 1'b0;
            end
            intRefEnable <= refSync;
        end
    end
endmodule : prb_result_bus

// >>> prb_result_bus_assertions.sv
// concurrent checks on the result bus block ports
`timescale 1ns/100ps
module prb_result_bus_assertions #(
    parameter int RESULT_W = 18, // result width
    parameter int BUS_W    = 16  // bus width
) (
    input wire logic                clk,                // system clock
    input wire logic                rst_n,              // async reset, active low
    input wire logic                chipSelect_n,       // select, active low
    input wire logic                readStrobe_n,       // read, active low
    input wire logic                conversion_start,   // start pin
    input wire logic                conversionDone,     // done pulse
    input wire logic                refSelect,          // reference select
    input wire logic                serialMode,         // serial chosen
    input wire logic                softwareMode,       // software mode
    input wire prb_pkg::prb_lines_e doutLines,          // line option
    input wire logic [RESULT_W-1:0] resultData,         // current result
    input wire logic                resultIsChannelOne, // channel one
    input wire logic [BUS_W-1:0]    busIn,              // line levels
    input wire logic [BUS_W-1:0]    busOut,             // drive values
    input wire logic [BUS_W-1:0]    busOe_n,            // enables, low drives
    input wire logic                serialIn,           // serial data in
    input wire logic                resultAdvance,      // pair read
    input wire logic                busy,               // converting
    input wire logic                first_channel_flag, // channel one flag
    input wire logic                intRefEnable        // internal reference
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] idleCnt; // cycles with pins not both low
    logic [3:0] actCnt;  // cycles with a parallel read held
    wire logic  wide = (doutLines == prb_pkg::PRB_DOUT_FOUR) || (doutLines == prb_pkg::PRB_DOUT_EIGHT);
    // saturating counters of pin activity
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idleCnt <= 4'h0;
            actCnt  <= 4'h0;
        end else begin
            idleCnt <= (chipSelect_n || readStrobe_n) ? idleCnt + 4'(idleCnt != 4'hF) : 4'h0;
            actCnt  <= (!chipSelect_n && !readStrobe_n && !serialMode) ? actCnt + 4'(actCnt != 4'hF) : 4'h0;
        end
    end
    AST_IDLE_HIZ: assert property (idleCnt >= 4'h8 && !serialMode |-> busOe_n == '1)
        else $error("bus driven outside a read");
    AST_DRIVE: assert property (actCnt == 4'h6 |-> busOe_n == '0)
        else $error("bus not driven during a read");
    AST_SECOND: assert property (resultAdvance && !serialMode |->
        $past(busOut[13:0]) == 14'h0000 && $past(busOut[15:14]) == $past(resultData[1:0]))
        else $error("second pulse data wrong");
    AST_SER_CD: assert property (($stable(doutLines) && serialMode && softwareMode)[*3] |->
        busOe_n[10:9] == {2{!wide}})
        else $error("serial outputs C and D enable wrong");
    AST_SDI: assert property (($stable(busIn[11]) && serialMode && softwareMode)[*8] |->
        serialIn == busIn[11])
        else $error("serial input not followed");
    AST_REF: assert property (($stable(refSelect))[*8] |-> intRefEnable == refSelect)
        else $error("reference enable wrong");
    AST_BUSY_UP: assert property ($rose(conversion_start) |-> ##[1:8] busy)
        else $error("busy did not rise");
    AST_BUSY_HOLD: assert property (busy && !conversionDone |=> busy)
        else $error("busy dropped early");
    AST_FLAG: assert property ((serialMode && resultIsChannelOne && !chipSelect_n)[*8] |-> first_channel_flag)
        else $error("first channel flag missing");
endmodule : prb_result_bus_assertions
